// >>> wm_consts.svh
// Offsets, field positions, reset values and timing constants of the wireless mode controller.
`ifndef WM_CONSTS_SVH
`define WM_CONSTS_SVH

`define WM_CLK_HZ 50000000
`define WM_TICK_US 1000
`define WM_TICK_CYC (`WM_CLK_HZ / 1000000 * `WM_TICK_US)

`define WM_SESSION_MIN 5
`define WM_REFRESH_MIN 2
`define WM_RETRY_MIN 1
`define WM_SOLID_S 2
`define WM_IDLE_S 4
`define WM_FLASH_MS 100
`define WM_DB_MS 20
`define WM_MAX_STA 8
`define WM_TW 19

`define WM_OFS_CTRL 12'h000
`define WM_OFS_STA_ADDR 12'h004
`define WM_OFS_STATUS 12'h008
`define WM_OFS_NET_ADDR 12'h00c

`define WM_CTRL_MODE_LSB 0
`define WM_CTRL_PW_BIT 3
`define WM_CTRL_APPLY_BIT 8

`define WM_MODE_RESET 3'h2
`define WM_LL_PREFIX 16'ha9fe
`define WM_LL_LOW 16'h0001

`endif

// >>> wm_pkg.sv
// Types shared by the wireless mode controller and its submodules.
`default_nettype none
package wm_pkg;

	typedef enum logic [2:0] {
		MODE_JOIN = 3'b000,
		MODE_HOST = 3'b001,
		MODE_OFF_JOIN = 3'b010,
		MODE_OFF_HOST = 3'b011,
		MODE_JOIN_HOST = 3'b100,
		MODE_DISABLE = 3'b101
	} mode_t;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_JOIN_TRY = 3'b001,
		ST_JOINED = 3'b010,
		ST_JOIN_WAIT = 3'b011,
		ST_HOST_TRY = 3'b100,
		ST_HOSTING = 3'b101,
		ST_HOST_WAIT = 3'b110,
		ST_DISABLED = 3'b111
	} state_t;

	typedef struct packed {
		logic joined;
		logic created;
		logic failed;
		logic activity;
		logic tx;
		logic rx;
		logic dhcp_ok;
		logic dhcp_fail;
	} radio_evt_t;

	typedef struct packed {
		logic power;
		logic join_req;
		logic host_req;
		logic wpa2;
		logic default_name;
		logic use_dhcp;
		logic traffic_en;
		logic sta_accept;
	} radio_ctl_t;

endpackage
`default_nettype wire

// >>> wm_debounce.sv
// Button synchroniser and debouncer giving one pulse per press.
`default_nettype none
`include "wm_consts.svh"
module wm_debounce #(
	parameter int unsigned DB_MS = `WM_DB_MS
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic button_n_i,
	output logic press_o
);
	logic sync1_reg;
	logic sync2_reg;
	logic stable_reg;
	logic [7:0] cnt_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= ~button_n_i;
			sync2_reg <= sync1_reg;
		end
	end

	// A level must hold for the whole debounce time before it is accepted.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stable_reg <= 1'b0;
			cnt_reg <= 8'h00;
			press_o <= 1'b0;
		end else begin
			press_o <= 1'b0;
			if (sync2_reg == stable_reg) begin
				cnt_reg <= 8'h00;
			end else if (tick_i) begin
				if (cnt_reg == 8'(DB_MS - 1)) begin
					cnt_reg <= 8'h00;
					stable_reg <= sync2_reg;
					press_o <= sync2_reg; // [RULE22]
				end else begin
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> wm_timer.sv
// Millisecond down counter with load, extend-to-minimum and expiry pulse.
`default_nettype none
`include "wm_consts.svh"
module wm_timer #(
	parameter int unsigned W = `WM_TW
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	input wire logic ext_i,
	input wire logic [W-1:0] ext_val_i,
	output logic [W-1:0] count_o,
	output logic done_o
);
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (load_i) begin
				count_o <= load_val_i;
			end else if (ext_i && count_o != '0 && count_o < ext_val_i) begin
				count_o <= ext_val_i;
			end else if (tick_i && count_o != '0) begin
				count_o <= count_o - W'(1);
				done_o <= (count_o == W'(1));
			end
		end
	end
endmodule
`default_nettype wire

// >>> wireless_ctrl.sv
// Wireless radio mode controller with button, timeouts, retry, status LED and APB registers.
// What this block does
// RULE1: Join mode scans and joins; on failure powers down and retries each minute.
// RULE2: Button presses are ignored in permanent join and permanent host modes.
// RULE3: Permanent join: solid green joining, green flashes joined, red flashes awaiting retry.
// RULE4: Host mode creates the named network and accepts at most eight stations.
// RULE5: Hosted network uses WPA2 when a password is set, otherwise open.
// RULE6: Host modes show solid amber while creating and amber flashes while hosting.
// RULE7: Normally-off join powers and joins on a press; timeout or press powers off.
// RULE8: Normally-off sessions last five minutes; each sent message extends to two minutes.
// RULE9: Normally-off host starts hosting on a press; timeout or press shuts radio.
// RULE10: Normally-off modes turn the LED off when the radio loses power.
// RULE11: Join-then-host: press hosts an open default-named network; timeout or press rejoins.
// RULE12: Temporary hosting lasts five minutes; each received message extends to two minutes.
// RULE13: No traffic on the joined network while the temporary network is hosted.
// RULE14: Join-then-host shows green join indications, then amber after a press.
// RULE15: Disable mode turns off wireless and removes radio power.
// RULE16: LED is off on low supply, when disabled, or while awaiting retry; here join mode flashes red while awaiting retry.
// RULE17: LED is solidly lit for two seconds while joining or creating.
// RULE18: Once connected, LED flashes on activity and every four seconds when idle.
// RULE19: Reset selects normally-off join mode.
// RULE20: All-zero station address selects DHCP; the result is reported in status.
// RULE21: Without a DHCP answer a link-local address is reported.
// RULE22: The button is debounced into one event per press.
// RULE23: Six modes use a three-bit field, taking effect only on apply.
//
// Chosen here: the APB interface to the registers and the register addresses.
`default_nettype none
`include "wm_consts.svh"
module wireless_ctrl #(
	parameter int unsigned TICK_CYC = `WM_TICK_CYC,
	parameter int unsigned SESSION_MS = `WM_SESSION_MIN * 60000,
	parameter int unsigned REFRESH_MS = `WM_REFRESH_MIN * 60000,
	parameter int unsigned RETRY_MS = `WM_RETRY_MIN * 60000,
	parameter int unsigned SOLID_MS = `WM_SOLID_S * 1000,
	parameter int unsigned IDLE_MS = `WM_IDLE_S * 1000,
	parameter int unsigned FLASH_MS = `WM_FLASH_MS,
	parameter int unsigned DB_MS = `WM_DB_MS,
	parameter int unsigned MAX_STA = `WM_MAX_STA
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic button_n_i,
	input wire logic supply_ok_i,
	input wire wm_pkg::radio_evt_t radio_evt_i,
	input wire logic [3:0] sta_count_i,
	input wire logic [31:0] dhcp_addr_i,
	output wm_pkg::radio_ctl_t radio_ctl_o,
	output logic led_green_o,
	output logic led_red_o
);
	localparam int TW = `WM_TW;

	logic [15:0] div_reg;
	logic tick_reg;
	logic press;
	logic sup1_reg;
	logic sup2_reg;

	logic [2:0] mode_pend_reg;
	logic pw_reg;
	logic [31:0] sta_addr_reg;
	logic [31:0] net_addr_reg;
	wm_pkg::mode_t mode_reg;
	wm_pkg::state_t state_reg;
	wm_pkg::state_t state_next;
	logic temp_reg;
	logic temp_next;
	logic apply;
	logic wr_en;
	logic rd_en;

	logic press_ok;
	logic sess_load;
	logic [TW-1:0] sess_val;
	logic sess_ext;
	logic [TW-1:0] sess_cnt;
	logic sess_done;
	logic retry_load;
	logic [TW-1:0] retry_cnt;
	logic retry_done;

	logic [TW-1:0] solid_reg;
	logic [TW-1:0] idle_reg;
	logic [TW-1:0] flash_reg;
	logic trying_next;
	logic trying_now;
	logic flash_on;
	logic host_side;
	logic green_next;
	logic red_next;

	// Millisecond enable pulse.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (div_reg == 16'(TICK_CYC - 1));
			if (div_reg == 16'(TICK_CYC - 1)) begin
				div_reg <= 16'h0000;
			end else begin
				div_reg <= div_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sup1_reg <= 1'b0;
			sup2_reg <= 1'b0;
		end else begin
			sup1_reg <= supply_ok_i;
			sup2_reg <= sup1_reg;
		end
	end

	wm_debounce #(
		.DB_MS(DB_MS)
	) u_debounce (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.tick_i(tick_reg),
		.button_n_i(button_n_i),
		.press_o(press)
	);

	// APB slave with one wait state: pready rises in the second access cycle.
	assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
	assign rd_en = psel_i & penable_i & ~pready_o & ~pwrite_i;
	assign apply = wr_en & (paddr_i == `WM_OFS_CTRL) & pwdata_i[`WM_CTRL_APPLY_BIT];

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end else begin
			pready_o <= psel_i & penable_i & ~pready_o;
			pslverr_o <= psel_i & penable_i & ~pready_o &
				(paddr_i[11:4] != 8'h00 || paddr_i[1:0] != 2'b00);
			if (rd_en) begin
				case (paddr_i)
					`WM_OFS_CTRL: prdata_o <= {28'h0000000, pw_reg, mode_pend_reg};
					`WM_OFS_STA_ADDR: prdata_o <= sta_addr_reg;
					`WM_OFS_STATUS: prdata_o <= {16'h0000, (sta_addr_reg == 32'h00000000),
						mode_reg, sta_count_i, temp_reg, led_red_o, led_green_o,
						radio_ctl_o.power, 1'b0, state_reg};
					`WM_OFS_NET_ADDR: prdata_o <= net_addr_reg;
					default: prdata_o <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_pend_reg <= `WM_MODE_RESET; // [RULE19]
			pw_reg <= 1'b0;
			sta_addr_reg <= 32'h00000000;
		end else if (wr_en) begin
			if (paddr_i == `WM_OFS_CTRL) begin
				mode_pend_reg <= pwdata_i[`WM_CTRL_MODE_LSB +: 3];
				pw_reg <= pwdata_i[`WM_CTRL_PW_BIT];
			end
			if (paddr_i == `WM_OFS_STA_ADDR) begin
				sta_addr_reg <= pwdata_i;
			end
		end
	end

	// The active mode changes only on apply; unknown codes fall back to disable.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= wm_pkg::MODE_OFF_JOIN; // [RULE19]
		end else if (apply) begin
			if (mode_pend_reg > 3'h5) begin
				mode_reg <= wm_pkg::MODE_DISABLE;
			end else begin
				mode_reg <= wm_pkg::mode_t'(mode_pend_reg); // [RULE23]
			end
		end
	end

	// Reported network address: static, DHCP result, or link-local fallback.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			net_addr_reg <= 32'h00000000;
		end else if (sta_addr_reg != 32'h00000000) begin
			net_addr_reg <= sta_addr_reg;
		end else if (radio_evt_i.dhcp_ok) begin
			net_addr_reg <= dhcp_addr_i; // [RULE20]
		end else if (radio_evt_i.dhcp_fail) begin
			net_addr_reg <= {`WM_LL_PREFIX, `WM_LL_LOW}; // [RULE21]
		end
	end

	assign press_ok = press & (mode_reg == wm_pkg::MODE_OFF_JOIN ||
		mode_reg == wm_pkg::MODE_OFF_HOST || mode_reg == wm_pkg::MODE_JOIN_HOST); // [RULE2]

	// Mode sequencing. Priority: apply, button, session timeout, radio progress.
	always_comb begin
		state_next = state_reg;
		temp_next = temp_reg;
		sess_load = 1'b0;
		sess_val = TW'(SESSION_MS);
		case (state_reg)
			wm_pkg::ST_JOIN_TRY: begin
				if (radio_evt_i.joined) begin
					state_next = wm_pkg::ST_JOINED;
				end else if (radio_evt_i.failed) begin
					state_next = wm_pkg::ST_JOIN_WAIT; // [RULE1]
				end
			end
			wm_pkg::ST_HOST_TRY: begin
				if (radio_evt_i.created) begin
					state_next = wm_pkg::ST_HOSTING;
				end else if (radio_evt_i.failed) begin
					state_next = wm_pkg::ST_HOST_WAIT;
				end
			end
			wm_pkg::ST_JOIN_WAIT: begin
				if (retry_done) begin
					state_next = wm_pkg::ST_JOIN_TRY; // [RULE1]
				end
			end
			wm_pkg::ST_HOST_WAIT: begin
				if (retry_done) begin
					state_next = wm_pkg::ST_HOST_TRY;
				end
			end
			default: begin
			end
		endcase
		if (apply) begin
			temp_next = 1'b0;
			sess_load = 1'b1;
			sess_val = '0;
			case (mode_pend_reg)
				3'h0, 3'h4: state_next = wm_pkg::ST_JOIN_TRY;
				3'h1: state_next = wm_pkg::ST_HOST_TRY;
				3'h2, 3'h3: state_next = wm_pkg::ST_OFF;
				default: state_next = wm_pkg::ST_DISABLED; // [RULE15]
			endcase
		end else if (press_ok) begin
			sess_load = 1'b1;
			if (mode_reg == wm_pkg::MODE_JOIN_HOST) begin
				if (temp_reg) begin
					temp_next = 1'b0;
					sess_val = '0;
					state_next = wm_pkg::ST_JOIN_TRY; // [RULE11]
				end else begin
					temp_next = 1'b1;
					state_next = wm_pkg::ST_HOST_TRY; // [RULE11] [RULE13]
				end
			end else if (state_reg == wm_pkg::ST_OFF) begin
				if (mode_reg == wm_pkg::MODE_OFF_HOST) begin
					state_next = wm_pkg::ST_HOST_TRY; // [RULE9]
				end else begin
					state_next = wm_pkg::ST_JOIN_TRY; // [RULE7]
				end
			end else begin
				sess_val = '0;
				state_next = wm_pkg::ST_OFF; // [RULE7] [RULE9]
			end
		end else if (sess_done) begin
			if (mode_reg == wm_pkg::MODE_JOIN_HOST) begin
				temp_next = 1'b0;
				state_next = wm_pkg::ST_JOIN_TRY; // [RULE11]
			end else if (mode_reg == wm_pkg::MODE_OFF_JOIN || mode_reg == wm_pkg::MODE_OFF_HOST) begin
				state_next = wm_pkg::ST_OFF; // [RULE7] [RULE9]
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= wm_pkg::ST_OFF;
			temp_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			temp_reg <= temp_next;
		end
	end

	// Session timeout: sent traffic refreshes normally-off, received traffic refreshes temporary hosting.
	assign sess_ext = ((mode_reg == wm_pkg::MODE_OFF_JOIN || mode_reg == wm_pkg::MODE_OFF_HOST) &
		radio_evt_i.tx) | (temp_reg & radio_evt_i.rx); // [RULE8] [RULE12]

	wm_timer #(
		.W(TW)
	) u_session (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.tick_i(tick_reg),
		.load_i(sess_load),
		.load_val_i(sess_val),
		.ext_i(sess_ext),
		.ext_val_i(TW'(REFRESH_MS)),
		.count_o(sess_cnt),
		.done_o(sess_done)
	);

	assign retry_load = (state_next == wm_pkg::ST_JOIN_WAIT || state_next == wm_pkg::ST_HOST_WAIT) &&
		state_next != state_reg;

	wm_timer #(
		.W(TW)
	) u_retry (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.tick_i(tick_reg),
		.load_i(retry_load),
		.load_val_i(TW'(RETRY_MS)),
		.ext_i(1'b0),
		.ext_val_i('0),
		.count_o(retry_cnt),
		.done_o(retry_done)
	);

	// Radio control; the wait states keep the radio in low power.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			radio_ctl_o <= '0;
		end else begin
			radio_ctl_o.power <= (state_reg == wm_pkg::ST_JOIN_TRY || state_reg == wm_pkg::ST_JOINED ||
				state_reg == wm_pkg::ST_HOST_TRY || state_reg == wm_pkg::ST_HOSTING); // [RULE15] [RULE1]
			radio_ctl_o.join_req <= (state_reg == wm_pkg::ST_JOIN_TRY || state_reg == wm_pkg::ST_JOINED);
			radio_ctl_o.host_req <= (state_reg == wm_pkg::ST_HOST_TRY || state_reg == wm_pkg::ST_HOSTING);
			radio_ctl_o.wpa2 <= pw_reg & ~temp_reg; // [RULE5] [RULE11]
			radio_ctl_o.default_name <= temp_reg; // [RULE11]
			radio_ctl_o.use_dhcp <= (sta_addr_reg == 32'h00000000); // [RULE20]
			radio_ctl_o.traffic_en <= (state_reg == wm_pkg::ST_JOINED) & ~temp_reg; // [RULE13]
			radio_ctl_o.sta_accept <= (state_reg == wm_pkg::ST_HOSTING) &
				(sta_count_i < 4'(MAX_STA)); // [RULE4]
		end
	end

	// LED timing: solid hold after a try starts, flash on activity or after four idle seconds.
	assign trying_next = (state_next == wm_pkg::ST_JOIN_TRY || state_next == wm_pkg::ST_HOST_TRY);
	assign trying_now = (state_reg == wm_pkg::ST_JOIN_TRY || state_reg == wm_pkg::ST_HOST_TRY);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			solid_reg <= '0;
		end else if (trying_next && !trying_now) begin
			solid_reg <= TW'(SOLID_MS); // [RULE17]
		end else if (tick_reg && solid_reg != '0) begin
			solid_reg <= solid_reg - TW'(1);
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			idle_reg <= '0;
			flash_reg <= '0;
		end else if (radio_evt_i.activity || (tick_reg && idle_reg == TW'(IDLE_MS - 1))) begin
			idle_reg <= '0;
			flash_reg <= TW'(FLASH_MS); // [RULE18]
		end else if (tick_reg) begin
			idle_reg <= idle_reg + TW'(1);
			if (flash_reg != '0) begin
				flash_reg <= flash_reg - TW'(1);
			end
		end
	end

	assign flash_on = (flash_reg != '0);
	assign host_side = (state_reg == wm_pkg::ST_HOST_TRY || state_reg == wm_pkg::ST_HOSTING);

	always_comb begin
		green_next = 1'b0;
		red_next = 1'b0;
		if (sup2_reg) begin
			case (state_reg)
				wm_pkg::ST_JOIN_TRY, wm_pkg::ST_HOST_TRY: begin
					green_next = 1'b1; // [RULE3] [RULE17]
					red_next = host_side; // [RULE6] [RULE14]
				end
				wm_pkg::ST_JOINED, wm_pkg::ST_HOSTING: begin
					green_next = (solid_reg != '0) | flash_on; // [RULE18]
					red_next = host_side & ((solid_reg != '0) | flash_on); // [RULE6] [RULE14]
				end
				wm_pkg::ST_JOIN_WAIT: begin
					red_next = (mode_reg == wm_pkg::MODE_JOIN) & flash_on; // [RULE3] [RULE16]
				end
				default: begin
				end
			endcase
		end
	end

	// Off on low supply, and whenever the radio is unpowered except for the red retry flashes of join mode.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			led_green_o <= 1'b0;
			led_red_o <= 1'b0;
		end else begin
			led_green_o <= green_next; // [RULE10] [RULE16]
			led_red_o <= red_next;
		end
	end
endmodule
`default_nettype wire

// >>> wc_props.sv
// Port-level assertions for the wireless mode controller.
`default_nettype none
module wc_props #(
	parameter int unsigned MAX_STA = 8
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic supply_ok_i,
	input wire logic [3:0] sta_count_i,
	input wire wm_pkg::radio_ctl_t radio_ctl_o,
	input wire logic led_green_o,
	input wire logic led_red_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_access;
		psel_i && penable_i && !$past(penable_i);
	endsequence
	sequence s_green;
		(led_green_o && !led_red_o) [*8];
	endsequence
	sequence s_amber;
		(led_green_o && led_red_o) [*8];
	endsequence
	property p_wait;
		s_access |-> !pready_o ##1 pready_o;
	endproperty
	a_wait: assert property (p_wait) else $error("ready not in second access cycle");
	property p_pulse;
		pready_o |=> !pready_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	property p_err;
		pslverr_o |-> pready_o;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_dark;
		!supply_ok_i [*5] |-> !led_green_o && !led_red_o;
	endproperty
	a_dark: assert property (p_dark) else $error("indicator lit on low supply");
	property p_open;
		radio_ctl_o.default_name |-> !radio_ctl_o.wpa2 && !radio_ctl_o.traffic_en;
	endproperty
	a_open: assert property (p_open) else $error("temporary network secured or joined traffic");
	property p_unpowered;
		!radio_ctl_o.power |-> !radio_ctl_o.join_req && !radio_ctl_o.host_req;
	endproperty
	a_unpowered: assert property (p_unpowered) else $error("request while radio unpowered");
	property p_cap;
		(sta_count_i >= 4'(MAX_STA)) [*3] |-> !radio_ctl_o.sta_accept;
	endproperty
	a_cap: assert property (p_cap) else $error("station accepted beyond limit");
	property p_join_solid;
		$rose(radio_ctl_o.join_req) && supply_ok_i |=> s_green;
	endproperty
	a_join_solid: assert property (p_join_solid) else $error("green not solid on join");
	property p_host_solid;
		$rose(radio_ctl_o.host_req) && supply_ok_i |=> s_amber;
	endproperty
	a_host_solid: assert property (p_host_solid) else $error("amber not solid on create");
endmodule
bind wireless_ctrl wc_props #(.MAX_STA(MAX_STA)) props_u (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pready_o,
	.pslverr_o, .supply_ok_i, .sta_count_i, .radio_ctl_o, .led_green_o, .led_red_o);
`default_nettype wire

// >>> radio_model.sv
// Behavioural radio module and push button facing the controller.
`default_nettype none
module radio_model (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire wm_pkg::radio_ctl_t radio_ctl_i,
	input wire logic fail_i,
	input wire logic dhcp_bad_i,
	input wire logic [7:0] lat_i,
	input wire logic press_i,
	input wire logic [2:0] traffic_i,
	output wm_pkg::radio_evt_t radio_evt_o,
	output logic button_n_o
);
	logic [1:0] req, req_q;
	logic [7:0] cnt;
	logic busy, done, ok_join;
	// The button contact has a pull-up, so a released button reads high.
	assign button_n_o = !press_i;
	assign req = {radio_ctl_i.join_req, radio_ctl_i.host_req};
	assign done = busy && cnt == lat_i && req != 2'b00;
	assign ok_join = done && !fail_i && req[1];
	assign radio_evt_o = wm_pkg::radio_evt_t'({ok_join, done && !fail_i && req[0], done && fail_i, traffic_i,
		ok_join && radio_ctl_i.use_dhcp && !dhcp_bad_i, ok_join && radio_ctl_i.use_dhcp && dhcp_bad_i});
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_q <= 2'h0;
			busy <= 1'b0;
			cnt <= 8'h00;
		end else begin
			req_q <= req;
			cnt <= busy ? cnt + 8'h01 : 8'h00;
			if (|(req & ~req_q))
				busy <= 1'b1;
			else if (done || req == 2'b00)
				busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> wireless_mode_button_led_control_test.sv
// Self-checking testbench for the wireless mode controller.
`default_nettype none
module wireless_mode_button_led_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0] mode;
		logic pw;
		logic push;
		logic [2:0] st;
		logic wpa2;
	} row_t;
	localparam logic [31:0] DHCP_ADDR = 32'hc0a80117;
	logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, button_n, led_g, led_r, rerr;
	logic supply_ok = 1'b1, fail = 1'b0, dhcp_bad = 1'b0, push = 1'b0;
	logic [3:0] sta_count = 4'h0;
	logic [7:0] lat = 8'h14;
	logic [2:0] traffic = 3'h0;
	wm_pkg::radio_evt_t evt;
	wm_pkg::radio_ctl_t ctl;
	int checks = 0, n_mismatch = 0, cyc = 0, n_on;
	row_t rows [11] = '{'{3'h1, 1'b1, 1'b0, 3'h5, 1'b1}, '{3'h0, 1'b0, 1'b1, 3'h2, 1'b0},
		'{3'h1, 1'b0, 1'b1, 3'h5, 1'b0}, '{3'h2, 1'b0, 1'b0, 3'h0, 1'b0}, '{3'h2, 1'b0, 1'b1, 3'h2, 1'b0},
		'{3'h3, 1'b1, 1'b1, 3'h5, 1'b1}, '{3'h4, 1'b0, 1'b0, 3'h2, 1'b0}, '{3'h5, 1'b0, 1'b1, 3'h7, 1'b0},
		'{3'h6, 1'b0, 1'b0, 3'h7, 1'b0}, '{3'h0, 1'b0, 1'b0, 3'h2, 1'b0}, '{3'h7, 1'b0, 1'b0, 3'h7, 1'b0}};
	// One tick per clock keeps debounce, flash and idle times at their own values, counted in cycles.
	wireless_ctrl #(.TICK_CYC(1), .SESSION_MS(500), .REFRESH_MS(200), .RETRY_MS(100), .SOLID_MS(50)) dut_u (
		.sys_clk_i(sys_clk), .rst_i(rst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .button_n_i(button_n), .supply_ok_i(supply_ok),
		.radio_evt_i(evt), .sta_count_i(sta_count), .dhcp_addr_i(DHCP_ADDR), .radio_ctl_o(ctl),
		.led_green_o(led_g), .led_red_o(led_r));
	radio_model model_u (.sys_clk_i(sys_clk), .rst_i(rst), .radio_ctl_i(ctl), .fail_i(fail),
		.dhcp_bad_i(dhcp_bad), .lat_i(lat), .press_i(push), .traffic_i(traffic), .radio_evt_o(evt),
		.button_n_o(button_n));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cfg(input logic [2:0] m, input logic pw);
		apb(1'b1, 12'h000, {28'h0, pw, m});
		apb(1'b1, 12'h000, {23'h0, 1'b1, 4'h0, pw, m});
	endtask
	task automatic press;
		@(posedge sys_clk);
		push <= 1'b1;
		repeat (60) @(posedge sys_clk);
		push <= 1'b0;
		repeat (60) @(posedge sys_clk);
	endtask
	task automatic wait_st(input logic [2:0] st);
		do begin
			repeat (20) @(posedge sys_clk);
			apb(1'b0, 12'h008, 32'h0);
		end while (rdata[2:0] !== st);
	endtask
	task automatic count_led(input int n, input logic red);
		n_on = 0;
		repeat (n) begin
			@(negedge sys_clk);
			n_on += int'(red ? led_r : led_g);
		end
		@(posedge sys_clk);
	endtask
	task automatic hold_ext(input logic [2:0] t, input logic [2:0] st);
		traffic <= 3'h4;
		@(posedge sys_clk);
		traffic <= 3'h0;
		count_led(250, 1'b0);
		check(32'(n_on > 0 && n_on < 250), 32'h1);
		traffic <= t;
		@(posedge sys_clk);
		traffic <= 3'h0;
		repeat (150) @(posedge sys_clk);
		apb(1'b0, 12'h008, 32'h0);
		check(32'(rdata[2:0]), 32'(st));
	endtask
	task automatic reset_check;
		apb(1'b0, 12'h000, 32'h0);
		check(32'(rdata[2:0]), 32'h2);
		apb(1'b0, 12'h008, 32'h0);
		check(32'({rdata[14:12], rdata[4:0]}), 32'h40);
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		reset_check();
		apb(1'b1, 12'h004, 32'h0);
		cfg(3'h0, 1'b0);
		wait_st(3'h2);
		apb(1'b0, 12'h00c, 32'h0);
		check(rdata, DHCP_ADDR);
		foreach (rows[i]) begin
			lat <= 8'(i * 6);
			cfg(rows[i].mode, rows[i].pw);
			if (rows[i].push)
				press();
			wait_st(rows[i].st);
			check(32'(rdata[4:0]), 32'({rows[i].st != 3'h0 && rows[i].st != 3'h7, 1'b0, rows[i].st}));
			check(32'(ctl.wpa2), 32'(rows[i].wpa2));
			if (rows[i].mode < 3'h6)
				check(32'(rdata[14:12]), 32'(rows[i].mode));
		end
		apb(1'b0, 12'h010, 32'h0);
		check({31'h0, rerr} | rdata, 32'h1);
		apb(1'b1, 12'h006, 32'h5);
		check(32'(rerr), 32'h1);
		lat <= 8'h28;
		fail <= 1'b1;
		cfg(3'h0, 1'b0);
		wait_st(3'h3);
		check(32'(rdata[4]), 32'h0);
		traffic <= 3'h4;
		@(posedge sys_clk);
		traffic <= 3'h0;
		count_led(80, 1'b1);
		check(32'(n_on > 0), 32'h1);
		fail <= 1'b0;
		dhcp_bad <= 1'b1;
		wait_st(3'h2);
		apb(1'b0, 12'h00c, 32'h0);
		check(rdata, 32'ha9fe0001);
		apb(1'b1, 12'h004, 32'h0a000005);
		apb(1'b0, 12'h00c, 32'h0);
		check(rdata, 32'h0a000005);
		cfg(3'h1, 1'b0);
		wait_st(3'h5);
		sta_count <= 4'h8;
		repeat (5) @(posedge sys_clk);
		check(32'(ctl.sta_accept), 32'h0);
		sta_count <= 4'h7;
		supply_ok <= 1'b0;
		repeat (6) @(posedge sys_clk);
		check(32'({ctl.sta_accept, led_g, led_r}), 32'h4);
		supply_ok <= 1'b1;
		cfg(3'h2, 1'b0);
		press();
		wait_st(3'h2);
		hold_ext(3'h2, 3'h2);
		wait_st(3'h0);
		check(32'({rdata[4], led_g, led_r}), 32'h0);
		press();
		wait_st(3'h2);
		press();
		wait_st(3'h0);
		check(32'({rdata[4], led_g, led_r}), 32'h0);
		cfg(3'h4, 1'b1);
		wait_st(3'h2);
		press();
		wait_st(3'h5);
		check(32'({ctl.default_name, ctl.wpa2, ctl.traffic_en, rdata[7]}), 32'h9);
		hold_ext(3'h1, 3'h5);
		wait_st(3'h2);
		check(32'(ctl.default_name), 32'h0);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		reset_check();
		end_sim();
	end
endmodule
`default_nettype wire
